// >>> src/async_serial_baud_parity.sv
`timescale 1ns/10ps
`default_nettype none
module async_serial_baud_parity
  import serial_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             pt44_out,
  output logic             pt44_oe_n,
  input  wire logic        pt45_in
);

  state_t q;
  state_t d;
  logic   rx_fall;

  // true on the quarter tick that closes a bit
  function automatic logic bit_end(input logic tick, input logic [1:0] qcnt);
    bit_end = tick && (qcnt == QTR_LAST);
  endfunction : bit_end

  // parity over eight data bits, inverted for odd
  function automatic logic par8(input logic [7:0] data, input logic odd);
    par8 = (^data) ^ odd;
  endfunction : par8

  assign rx_fall   = q.rx_prev & ~q.rx_lvl;
  assign wb_dat_o  = q.dat;
  assign wb_ack_o  = q.ack;
  assign pt44_out  = q.tx_line;
  assign pt44_oe_n = q.tx_oe_n;

  // next state of the whole block
  always_comb begin
    logic       req;
    logic       wr;
    logic       wr_txd;
    logic       rx_run;
    logic       abd_run;
    logic       ninth;
    logic [7:0] rbyte;
    logic       drop;
    req     = 1'b0;
    wr      = 1'b0;
    wr_txd  = 1'b0;
    rx_run  = 1'b0;
    abd_run = 1'b0;
    ninth   = 1'b0;
    rbyte   = 8'h00;
    drop    = 1'b0;
    d       = q;
    d.ack   = 1'b0;
    d.qtick = 1'b0;

    // three-stage line synchroniser, level taken when stages two and three agree
    d.s1 = pt45_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    if (q.s2 == q.s3) begin
      d.rx_lvl = q.s3;
    end
    d.rx_prev = q.rx_lvl;

    // quarter-bit tick: reload every divisor+1 clocks, four per bit
    if (q.brg_cnt == 13'h0000) begin
      d.brg_cnt = q.div[12:0];
      d.qtick   = 1'b1;
    end else begin
      d.brg_cnt = q.brg_cnt - 13'h0001;
    end

    // pins follow the port enable
    d.tx_oe_n = ~q.spe;

    // wishbone classic slave, one wait state
    req = wb_cyc_i & wb_stb_i & ~q.ack;
    wr  = req & wb_we_i & wb_sel_i[0];
    if (req) begin
      d.ack = 1'b1;
      d.dat = 32'h0000_0000;
    end
    if (wr) begin
      unique case (wb_adr_i)
        OFF_CTRL: begin
          d.spe     = wb_dat_i[B_SPE];
          d.tx_en   = wb_dat_i[B_TXEN];
          d.tx9     = wb_dat_i[B_TX9];
          d.tx9d    = wb_dat_i[B_TX9D];
          d.par_odd = wb_dat_i[B_ODD];
          d.wake_on_receive_en     = wb_dat_i[B_WUE];
        end
        OFF_RXC: begin
          d.rx_en  = wb_dat_i[B_RXEN];
          d.rc9    = wb_dat_i[B_RC9];
          d.adt    = wb_dat_i[B_ADT];
          d.abd_en = wb_dat_i[B_ABD];
          if (!wb_dat_i[B_ABD]) begin
            d.ovf = 1'b0;
          end
        end
        OFF_STAT: begin
          if (!wb_dat_i[B_OVF]) begin
            d.ovf = 1'b0;
          end
        end
        OFF_DIVH: d.div[15:8] = wb_dat_i[7:0];
        OFF_DIVL: d.div[7:0] = wb_dat_i[7:0];
        OFF_TXD: begin
          d.tx_buf  = wb_dat_i[7:0];
          d.tx_full = 1'b1;
          wr_txd    = 1'b1;
        end
        default: ;
      endcase
    end
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        OFF_CTRL: d.dat[5:0] = {q.wake_on_receive_en, q.par_odd, q.tx9d, q.tx9, q.tx_en, q.spe};
        OFF_RXC:  d.dat[3:0] = {q.abd_en, q.adt, q.rc9, q.rx_en};
        OFF_STAT: d.dat[7:0] = {q.rx_ready, q.ovf, (q.tx_st == TX_IDLE) && !q.tx_full,
                                q.rx_st == RX_IDLE, q.oe, q.fe, q.parity_error_flag, q.rx9};
        OFF_DIVH: d.dat[7:0] = q.div[15:8];
        OFF_DIVL: d.dat[7:0] = q.div[7:0];
        OFF_TXD:  d.dat[7:0] = q.tx_buf;
        OFF_RXD: begin
          d.dat[7:0] = q.rx_data;
          d.rx_ready = 1'b0;
        end
        default: ;
      endcase
    end

    // transmitter, independent of the receiver, same rate and format
    unique case (q.tx_st)
      TX_IDLE: begin
        if (q.tx_en && q.spe && q.tx_full) begin
          if (q.tx9 && !q.rc9) begin
            ninth = par8(q.tx_buf, q.par_odd);
          end else begin
            ninth = q.tx9d;
          end
          d.tx_sh   = {ninth, q.tx_buf};
          d.tx_full = wr_txd;
          d.tx_st   = TX_START;
          d.tx_q    = 2'h0;
          d.tx_line = 1'b0;
        end
      end
      TX_START: begin
        if (q.qtick) begin
          d.tx_q = q.tx_q + 2'h1;
        end
        if (bit_end(q.qtick, q.tx_q)) begin
          d.tx_st   = TX_DATA;
          d.tx_bits = 4'h0;
          d.tx_line = q.tx_sh[0];
        end
      end
      TX_DATA: begin
        if (q.qtick) begin
          d.tx_q = q.tx_q + 2'h1;
        end
        if (bit_end(q.qtick, q.tx_q)) begin
          if (q.tx_bits == (q.tx9 ? LAST9 : LAST8)) begin
            d.tx_st   = TX_STOP;
            d.tx_line = 1'b1;
          end else begin
            d.tx_sh   = {1'b0, q.tx_sh[8:1]};
            d.tx_line = q.tx_sh[1];
            d.tx_bits = q.tx_bits + 4'h1;
          end
        end
      end
      TX_STOP: begin
        if (q.qtick) begin
          d.tx_q = q.tx_q + 2'h1;
        end
        if (bit_end(q.qtick, q.tx_q)) begin
          d.tx_st = TX_IDLE;
        end
      end
    endcase

    // receiver, idle while auto-rate or wake-on-receive is active
    rx_run = q.rx_en & q.spe & ~q.wake_on_receive_en & ~q.abd_en;
    unique case (q.rx_st)
      RX_IDLE: begin
        if (rx_fall) begin
          d.rx_st = RX_START;
          d.rx_q  = 2'h0;
        end
      end
      RX_START: begin
        if (q.qtick) begin
          d.rx_q = q.rx_q + 2'h1;
          if (q.rx_q == QTR_MID) begin
            d.rx_q = 2'h0;
            // false start if the line is high again mid start bit
            d.rx_st   = q.rx_lvl ? RX_IDLE : RX_DATA;
            d.rx_bits = 4'h0;
          end
        end
      end
      RX_DATA: begin
        if (q.qtick) begin
          d.rx_q = q.rx_q + 2'h1;
        end
        if (bit_end(q.qtick, q.rx_q)) begin
          d.rx_sh   = {q.rx_lvl, q.rx_sh[8:1]};
          d.rx_bits = q.rx_bits + 4'h1;
          if (q.rx_bits == (q.rc9 ? LAST9 : LAST8)) begin
            d.rx_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (q.qtick) begin
          d.rx_q = q.rx_q + 2'h1;
        end
        if (bit_end(q.qtick, q.rx_q)) begin
          d.rx_st = RX_IDLE;
          d.fe    = ~q.rx_lvl;
          rbyte   = q.rc9 ? q.rx_sh[7:0] : q.rx_sh[8:1];
          ninth   = q.rc9 & q.rx_sh[8];
          // address test drops frames whose ninth bit is clear
          drop    = q.rc9 & q.adt & ~ninth;
          if (!drop) begin
            if (q.rx_ready && d.rx_ready) begin
              d.oe = 1'b1;
            end else begin
              d.rx_data  = rbyte;
              d.rx9      = ninth;
              d.parity_error_flag     = q.rc9 & ~q.adt & (par8(rbyte, q.par_odd) ^ ninth);
              d.rx_ready = 1'b1;
            end
          end
        end
      end
    endcase
    if (!rx_run) begin
      d.rx_st = RX_IDLE;
    end
    if (!q.rx_en) begin
      d.fe = 1'b0;
      d.oe = 1'b0;
    end

    // auto-rate: time four bit pairs of 0x55, 32 clocks per count
    abd_run = q.abd_en & ~q.wake_on_receive_en & q.spe;
    unique case (q.abd_st)
      AB_IDLE: begin
        if (abd_run && rx_fall) begin
          d.abd_st    = AB_MEAS;
          d.abd_edges = 3'h0;
          d.abd_pre   = 5'h00;
          d.abd_cnt   = 13'h0000;
        end
      end
      AB_MEAS: begin
        d.abd_pre = q.abd_pre + 5'h01;
        if (q.abd_pre == ABD_PRE_LAST) begin
          d.abd_cnt = q.abd_cnt + 13'h0001;
          if (q.abd_cnt == CNT_MAX) begin
            d.ovf = 1'b1;
          end
        end
        if (rx_fall) begin
          d.abd_edges = q.abd_edges + 3'h1;
          if (q.abd_edges == ABD_EDGE_LAST) begin
            d.div      = {3'h0, q.abd_cnt - 13'h0001};
            d.abd_en   = 1'b0;
            d.rx_ready = 1'b1;
            d.abd_st   = AB_IDLE;
          end
        end
      end
    endcase
    if (!abd_run) begin
      d.abd_st = AB_IDLE;
    end
  end

  // single state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= STATE_RESET;
    end else begin
      q <= d;
    end
  end

  // checks on bus, line and flags
  a_ack_single_pulse: assert property (@(posedge clk) disable iff (!nrst)
    q.ack |=> !q.ack) else $error("ack held longer than one cycle");
  a_tick_reload: assert property (@(posedge clk) disable iff (!nrst)
    q.qtick |-> q.brg_cnt == $past(q.div[12:0])) else $error("timer not reloaded");
  a_false_start_drop: assert property (@(posedge clk) disable iff (!nrst)
    (q.rx_st == RX_START && q.qtick && q.rx_q == QTR_MID && q.rx_lvl) |=> q.rx_st == RX_IDLE)
    else $error("false start accepted");
  a_abd_gate: assert property (@(posedge clk) disable iff (!nrst)
    (q.abd_st == AB_IDLE && !(q.abd_en && !q.wake_on_receive_en && q.spe)) |=> q.abd_st == AB_IDLE)
    else $error("auto-rate started while disallowed");
  a_abd_result: assert property (@(posedge clk) disable iff (!nrst)
    (q.abd_st == AB_MEAS && rx_fall && q.abd_edges == ABD_EDGE_LAST)
    |=> (q.div == {3'h0, $past(q.abd_cnt) - 13'h0001}) && !q.abd_en && q.rx_ready)
    else $error("auto-rate result not stored");
  a_ovf_on_wrap: assert property (@(posedge clk) disable iff (!nrst)
    (q.abd_st == AB_MEAS && q.abd_pre == ABD_PRE_LAST && q.abd_cnt == CNT_MAX) |=> q.ovf)
    else $error("overflow not flagged");
  a_ovf_keeps_en: assert property (@(posedge clk) disable iff (!nrst)
    $rose(q.ovf) |-> q.abd_en) else $error("enable dropped on overflow");
  a_tx_parity: assert property (@(posedge clk) disable iff (!nrst)
    ($rose(q.tx_st == TX_START) && $past(q.tx9) && !$past(q.rc9))
    |-> q.tx_sh[8] == par8(q.tx_sh[7:0], $past(q.par_odd))) else $error("bad tx parity");
  a_parity_error_flag_source: assert property (@(posedge clk) disable iff (!nrst)
    $rose(q.parity_error_flag) |-> $past(q.rc9) && !$past(q.adt)) else $error("parity flag in wrong mode");
  a_err_clear_off: assert property (@(posedge clk) disable iff (!nrst)
    !q.rx_en |=> !q.fe && !q.oe) else $error("error flags survive receive disable");
  a_pins_assigned: assert property (@(posedge clk) disable iff (!nrst)
    ##1 (q.tx_oe_n == !$past(q.spe))) else $error("pin drive not tied to port enable");
  a_line_high_idle: assert property (@(posedge clk) disable iff (!nrst)
    (q.tx_st == TX_IDLE || q.tx_st == TX_STOP) |-> q.tx_line) else $error("line low outside frame");

  // timer counts down by one between reloads
  a_brg_countdown: assert property (@(posedge clk) disable iff (!nrst)
    q.brg_cnt != 13'h0000 |=> q.brg_cnt == $past(q.brg_cnt) - 13'h0001)
    else $error("timer skipped a count");

  // software clears of the overflow flag, outside a measurement
  a_ovf_stat_clear: assert property (@(posedge clk) disable iff (!nrst)
    (wb_cyc_i && wb_stb_i && !q.ack && wb_we_i && wb_sel_i[0] && wb_adr_i == OFF_STAT
     && !wb_dat_i[B_OVF] && q.abd_st != AB_MEAS) |=> !q.ovf)
    else $error("overflow kept after zero write");
  a_ovf_en_clear: assert property (@(posedge clk) disable iff (!nrst)
    (wb_cyc_i && wb_stb_i && !q.ack && wb_we_i && wb_sel_i[0] && wb_adr_i == OFF_RXC
     && !wb_dat_i[B_ABD] && q.abd_st != AB_MEAS) |=> !q.ovf)
    else $error("overflow kept after enable clear");

  // plain eight-bit frames never report a parity error
  a_no_parity_8: assert property (@(posedge clk) disable iff (!nrst)
    (q.rx_st == RX_STOP && !q.rc9) ##1 (q.rx_st == RX_IDLE && $rose(q.rx_ready)) |-> !q.parity_error_flag)
    else $error("parity flag on plain frame");

  // receive flags and stored ninth bit
  a_overrun_src: assert property (@(posedge clk) disable iff (!nrst)
    $rose(q.oe) |-> $past(q.rx_ready) && $past(q.rx_st == RX_STOP))
    else $error("overrun without unread frame");
  a_rxd_read_clears: assert property (@(posedge clk) disable iff (!nrst)
    (wb_cyc_i && wb_stb_i && !q.ack && !wb_we_i && wb_adr_i == OFF_RXD
     && q.rx_st != RX_STOP && q.abd_st != AB_MEAS) |=> !q.rx_ready)
    else $error("receive event kept after data read");
  a_stop_to_fe: assert property (@(posedge clk) disable iff (!nrst)
    (q.rx_st == RX_STOP && bit_end(q.qtick, q.rx_q) && q.rx_en && q.spe && !q.wake_on_receive_en && !q.abd_en)
    |=> q.fe == !$past(q.rx_lvl)) else $error("framing flag not from stop bit");
  a_ninth_stored: assert property (@(posedge clk) disable iff (!nrst)
    ($rose(q.rx_ready) && $past(q.rx_st == RX_STOP))
    |-> q.rx9 == ($past(q.rc9) && $past(q.rx_sh[8]))) else $error("ninth bit not stored");

endmodule : async_serial_baud_parity
`default_nettype wire

// >>> include/serial_pkg.sv
// Notes on behaviour
// - bit rate equals clock divided by four times divisor plus one
// - baud timer is a 13-bit down counter reloaded from the divisor
// - receive line level is taken at the middle of each bit
// - auto-rate runs only with wake-on-receive off and auto-rate enabled
// - finished auto-rate measurement writes divisor high and low bytes
// - auto-rate count wrapping 0x1fff to zero sets the overflow flag
// - overflow flag cleared by writing zero or clearing auto-rate enable
// - overflow leaves auto-rate enable set
// - ninth tx on, ninth rx off: ninth bit is even or odd parity
// - ninth rx on: check ninth bit parity, flag mismatch as parity error
// - both ninth-bit controls off: frames carry no parity
// - ninth rx with address test: ninth bit marks address, parity ignored
// - frame is start bit, 8 or 9 data bits, one stop bit, NRZ
// - data bits travel least significant bit first
// - transmitter and receiver independent, shared format and rate
// - serial port enable hands both port pins to transmit and receive
// - clearing receive enable clears the framing error flag
// - ninth rx on: ninth bit to status, other eight to rx data
// - second unread frame sets overrun; clearing receive enable clears it
package serial_pkg;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RXC  = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_DIVH = 8'h0c;
  localparam logic [7:0] OFF_DIVL = 8'h10;
  localparam logic [7:0] OFF_TXD  = 8'h14;
  localparam logic [7:0] OFF_RXD  = 8'h18;
  // control register bits
  localparam int B_SPE  = 0;
  localparam int B_TXEN = 1;
  localparam int B_TX9  = 2;
  localparam int B_TX9D = 3;
  localparam int B_ODD  = 4;
  localparam int B_WUE  = 5;
  // receive and rate control bits
  localparam int B_RXEN = 0;
  localparam int B_RC9  = 1;
  localparam int B_ADT  = 2;
  localparam int B_ABD  = 3;
  // status bits
  localparam int B_RX9  = 0;
  localparam int B_PARITY_ERROR_FLAG = 1;
  localparam int B_FRAMING_ERROR_FLAG = 2;
  localparam int B_OVERRUN_ERROR_FLAG = 3;
  localparam int B_IDLE = 4;
  localparam int B_TEMP = 5;
  localparam int B_OVF  = 6;
  localparam int B_RDY  = 7;
  // timing counts
  localparam int          QUARTERS_PER_BIT = 4;
  localparam logic [1:0]  QTR_LAST         = 2'(QUARTERS_PER_BIT - 1);
  localparam logic [1:0]  QTR_MID          = 2'h1;
  localparam logic [4:0]  ABD_PRE_LAST     = 5'h1f;
  localparam logic [12:0] CNT_MAX          = 13'h1fff;
  localparam logic [2:0]  ABD_EDGE_LAST    = 3'h3;
  localparam logic [3:0]  LAST8            = 4'h7;
  localparam logic [3:0]  LAST9            = 4'h8;

  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_START = 2'b01, TX_DATA = 2'b10,
                            TX_STOP = 2'b11} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10,
                            RX_STOP = 2'b11} rx_state_t;
  typedef enum logic {AB_IDLE = 1'b0, AB_MEAS = 1'b1} abd_state_t;

  typedef struct packed {
    logic spe; logic tx_en; logic tx9; logic tx9d; logic par_odd; logic wake_on_receive_en;
    logic rx_en; logic rc9; logic adt; logic abd_en;
    logic [15:0] div;
    logic ack; logic [31:0] dat;
    logic s1; logic s2; logic s3; logic rx_lvl; logic rx_prev;
    logic [12:0] brg_cnt; logic qtick;
    tx_state_t tx_st; logic [7:0] tx_buf; logic tx_full; logic [8:0] tx_sh;
    logic [3:0] tx_bits; logic [1:0] tx_q; logic tx_line; logic tx_oe_n;
    rx_state_t rx_st; logic [8:0] rx_sh; logic [3:0] rx_bits; logic [1:0] rx_q;
    logic [7:0] rx_data; logic rx9; logic rx_ready; logic parity_error_flag; logic fe; logic oe;
    abd_state_t abd_st; logic [2:0] abd_edges; logic [4:0] abd_pre;
    logic [12:0] abd_cnt; logic ovf;
  } state_t;

  localparam state_t STATE_RESET = '{tx_st: TX_IDLE, rx_st: RX_IDLE, abd_st: AB_IDLE,
                                     s1: 1'b1, s2: 1'b1, s3: 1'b1, rx_lvl: 1'b1,
                                     rx_prev: 1'b1, tx_line: 1'b1, tx_oe_n: 1'b1,
                                     default: '0};
endpackage : serial_pkg

// >>> verif/serial_peer.sv
`timescale 1ns/10ps
`default_nettype none
// remote station: drives the receive pin and decodes the transmit pin
module serial_peer (
  input  wire logic       clk,
  input  wire logic       line_in,
  input  wire logic       nine,
  input  wire logic [9:0] bt,
  output logic            line_out,
  output logic      [9:0] got,
  output logic            got_stb
);
  logic [9:0] f;

  // one frame: start, n data bits lsb first, stop, then one idle bit
  task automatic send(input logic [8:0] d, input int n, input logic stp);
    @(posedge clk) line_out <= 1'b0;
    repeat (bt) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      line_out <= d[i];
      repeat (bt) @(posedge clk);
    end
    line_out <= stp;
    repeat (bt) @(posedge clk);
    line_out <= 1'b1;
    repeat (bt) @(posedge clk);
  endtask : send

  // decoder samples each bit at its middle; stop level lands in bit 9
  initial begin
    line_out = 1'b1;
    got      = '0;
    got_stb  = 1'b0;
    forever begin
      @(negedge line_in);
      repeat (bt / 2) @(posedge clk);
      f = '0;
      for (int i = 0; i <= 8 + nine; i++) begin
        repeat (bt) @(posedge clk);
        f[i] = line_in;
      end
      if (!nine) f = {f[8], 1'b0, f[7:0]};
      got     <= f;
      got_stb <= 1'b1;
      @(posedge clk) got_stb <= 1'b0;
    end
  end
endmodule : serial_peer
`default_nettype wire

// >>> verif/async_serial_baud_parity_tb.sv
`timescale 1ns/10ps
`default_nettype none
module async_serial_baud_parity_tb;
  import serial_pkg::*;
  typedef struct packed {logic [31:0] e; logic [31:0] m;} note_t;
  logic        clk, nrst, cyc, stb, we, nine, wb_ack_o, pt44_out, pt44_oe_n;
  logic        tx_line, rx_line, got_stb;
  logic [7:0]  adr, d, d2;
  logic [9:0]  bt, got;
  logic [31:0] wdat, rdat, wb_dat_o;
  note_t       nt;
  note_t       bq[$];
  logic [9:0]  fq[$];
  int          n_errors = 0;
  int          checked = 0;
  int          cycles = 0;

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  async_serial_baud_parity DUT (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pt44_out(pt44_out), .pt44_oe_n(pt44_oe_n), .pt45_in(rx_line));

  // pull-up holds the line high while the pin is not driven
  assign tx_line = pt44_oe_n ? 1'b1 : pt44_out;

  serial_peer peer (.clk(clk), .line_in(tx_line), .nine(nine), .bt(bt),
    .line_out(rx_line), .got(got), .got_stb(got_stb));

  // compare tasks, one per kind of result
  task automatic cmp_word(input logic [31:0] g, input note_t n);
    checked++;
    if ((g & n.m) !== (n.e & n.m)) begin
      n_errors++;
      $display("wrong value at %0t: read %h expected %h mask %h", $time, g, n.e, n.m);
    end
  endtask : cmp_word

  task automatic cmp_frame(input logic [9:0] g, input logic [9:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: frame %h expected %h", $time, g, e);
    end
  endtask : cmp_frame

  task automatic cmp_pin(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: pin enable %b expected %b", $time, g, e);
    end
  endtask : cmp_pin

  // classic wishbone cycle; the expected read value is noted first
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dd,
                     input logic [31:0] e, input logic [31:0] m);
    bq.push_back('{e, m});
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= dd;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    cyc  <= 1'b0;
    stb  <= 1'b0;
    we   <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] dd);
    bus(1'b1, a, dd, '0, '0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(1'b0, a, '0, e, m);
  endtask : rd

  // poll a status bit, bounded
  task automatic wait_bit(input int b);
    rdat = '0;
    for (int i = 0; i < 400 && rdat[b] !== 1'b1; i++) rd(OFF_STAT, '0, '0);
  endtask : wait_bit

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  // watcher takes the oldest note whenever a result appears
  always @(posedge clk) begin
    if (wb_ack_o === 1'b1 && bq.size() > 0) begin
      nt = bq.pop_front();
      if (nt.m !== '0) cmp_word(wb_dat_o, nt);
    end
    if (got_stb === 1'b1 && fq.size() > 0) cmp_frame(got, fq.pop_front());
  end

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      wrap_up;
    end
  end

  // main sequence
  initial begin
    nrst = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; nine = 1'b0;
    adr = '0; wdat = '0; rdat = '0; bt = 10'd16;
    void'($urandom(54570));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    cmp_pin(pt44_oe_n, 1'b1);
    rd(OFF_STAT, 32'h30, '1);
    wr(OFF_STAT, '0);
    rd(OFF_STAT, '0, 32'h40);
    rd(8'hfc, '0, '1);
    done("reset");
    wr(OFF_DIVH, 32'h20);
    wr(OFF_DIVL, 32'h03);
    wr(OFF_CTRL, 32'h13);
    repeat (2) @(posedge clk);
    cmp_pin(pt44_oe_n, 1'b0);
    d = 8'($urandom);
    d2 = 8'($urandom);
    fq.push_back({2'b10, d});
    fq.push_back({2'b10, d2});
    wr(OFF_TXD, {24'h0, d});
    wr(OFF_TXD, {24'h0, d2});
    wait_bit(B_TEMP);
    nine = 1'b1;
    for (int o = 0; o < 2; o++) begin
      d = 8'($urandom);
      wr(OFF_CTRL, 32'h07 | 32'(o << B_ODD));
      fq.push_back({1'b1, ^d ^ o[0], d});
      wr(OFF_TXD, {24'h0, d});
      wait_bit(B_TEMP);
    end
    nine = 1'b0;
    done("transmit");
    wr(OFF_RXC, 32'h01);
    d = 8'($urandom);
    peer.send({1'b0, d}, 8, 1'b1);
    wait_bit(B_RDY);
    rd(OFF_STAT, '0, 32'h0e);
    rd(OFF_RXD, {24'h0, d}, 32'hff);
    wr(OFF_RXC, 32'h03);
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom);
      wr(OFF_CTRL, 32'h01 | 32'(k[0] << B_ODD));
      peer.send({^d ^ k[0] ^ k[1], d}, 9, 1'b1);
      wait_bit(B_RDY);
      rd(OFF_STAT, {30'h0, k[1], ^d ^ k[0] ^ k[1]}, 32'h03);
      rd(OFF_RXD, {24'h0, d}, 32'hff);
    end
    done("receive parity");
    wr(OFF_RXC, 32'h01);
    peer.send({1'b0, d}, 8, 1'b0);
    wait_bit(B_RDY);
    rd(OFF_STAT, 32'h04, 32'h04);
    rd(OFF_RXD, '0, '0);
    wr(OFF_RXC, '0);
    rd(OFF_STAT, '0, 32'h04);
    wr(OFF_RXC, 32'h01);
    d2 = 8'($urandom);
    peer.send({1'b0, d}, 8, 1'b1);
    peer.send({1'b0, d2}, 8, 1'b1);
    rd(OFF_STAT, 32'h08, 32'h0c);
    rd(OFF_RXD, {24'h0, d}, 32'hff);
    wr(OFF_RXC, '0);
    rd(OFF_STAT, '0, 32'h08);
    done("errors");
    wr(OFF_RXC, 32'h06);
    wr(OFF_RXC, 32'h07);
    d2[0] = ~^d2[7:1];
    peer.send({1'b0, d}, 9, 1'b1);
    peer.send({1'b1, d2}, 9, 1'b1);
    wait_bit(B_RDY);
    rd(OFF_STAT, 32'h01, 32'h03);
    rd(OFF_RXD, {24'h0, d2}, 32'hff);
    wr(OFF_RXC, 32'h03);
    peer.send({1'b0, d}, 9, 1'b1);
    wait_bit(B_RDY);
    rd(OFF_STAT, '0, 32'h01);
    rd(OFF_RXD, {24'h0, d}, 32'hff);
    done("address test");
    bt = 10'd256;
    wr(OFF_CTRL, 32'h21);
    wr(OFF_RXC, 32'h08);
    peer.send(9'h055, 8, 1'b1);
    rd(OFF_DIVL, 32'h03, 32'hff);
    rd(OFF_RXC, 32'h08, 32'h08);
    wr(OFF_CTRL, 32'h01);
    peer.send(9'h055, 8, 1'b1);
    wait_bit(B_RDY);
    rd(OFF_RXC, '0, 32'h08);
    rd(OFF_DIVH, '0, 32'hff);
    rd(OFF_DIVL, 32'h3e, 32'hfe);
    rd(OFF_RXD, '0, '0);
    done("auto rate");
    wrap_up;
  end
endmodule : async_serial_baud_parity_tb
`default_nettype wire
